// file: core/scg_params.svh
// Register offsets, field layouts and reset values of the clock gate block
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

// Register byte offsets
`define SCG_OFS_RUN_CFG 12'h060
`define SCG_OFS_RUN_GATE 12'h104
`define SCG_OFS_SLEEP_GATE 12'h114
`define SCG_OFS_DEEP_GATE 12'h124
`define SCG_OFS_IRQ_STAT 12'h200
`define SCG_OFS_IRQ_MASK 12'h204
`define SCG_OFS_GATE_STAT 12'h208

// Implemented enable bits of the three gating registers
`define SCG_GATE_MASK 32'h070f_5337
`define SCG_GATE_RESET 32'h0000_0000

// Run clock configuration: auto clock gating bit
`define SCG_ACG_BIT 27
`define SCG_CFG_MASK 32'h0800_0000
`define SCG_CFG_RESET 32'h0000_0000

// Interrupt status bits
`define SCG_IRQ_FAULT 0
`define SCG_IRQ_SLEEP 1
`define SCG_IRQ_WAKE 2
`define SCG_IRQ_MASK_BITS 32'h0000_0007
`define SCG_IRQ_RESET 32'h0000_0000

`endif

// file: core/scg_pkg.sv
// Types shared by the clock gate block
package scg_pkg;
  typedef enum logic [1:0] {
    SCG_RUN = 2'b00,
    SCG_SLEEP = 2'b01,
    SCG_DEEP = 2'b10
  } scg_mode_t;
endpackage

// file: core/scg_gate_if.sv
// Gating registers and effective enables between register file and selector
`timescale 1ns/10ps
interface scg_gate_if;
  logic [31:0] run_en;
  logic [31:0] sleep_en;
  logic [31:0] deep_en;
  logic auto_clock_gating;
  scg_pkg::scg_mode_t mode;
  logic [31:0] eff_en;
  modport regs (output run_en, sleep_en, deep_en, auto_clock_gating, mode, input eff_en);
  modport sel (input run_en, sleep_en, deep_en, auto_clock_gating, mode, output eff_en);
endinterface

// file: core/scg_mode_sel.sv
// Picks the gating register that governs the current operating state
`timescale 1ns/10ps
module scg_mode_sel (
  // Register side
  scg_gate_if.sel gif
);
  // Sleep registers apply only with auto gating set
  wire use_run = (gif.mode == scg_pkg::SCG_RUN) || !gif.auto_clock_gating;
  wire use_deep = (gif.mode == scg_pkg::SCG_DEEP) && gif.auto_clock_gating;
  assign gif.eff_en = use_run ? gif.run_en :
                      use_deep ? gif.deep_en : gif.sleep_en;
endmodule

// file: core/scg_unit_gate.sv
// Glitch-free clock gates and disable holds for the peripheral units
`timescale 1ns/10ps
module scg_unit_gate #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Enables
  input wire logic [WIDTH-1:0] en,
  // Unit side
  output logic [WIDTH-1:0] unit_clock,
  output logic [WIDTH-1:0] unit_disable
);
  logic [WIDTH-1:0] en_l;

  // Latch while clock is low so a gated clock never carries a runt pulse
  always_latch begin
    if (!clock) begin
      en_l <= en;
    end
  end

  // Clock passes only when enabled
  assign unit_clock = {WIDTH{clock}} & en_l;

  // Disabled units held in disable from reset onward
  always_ff @(posedge clock) begin
    if (!resetn) begin
      unit_disable <= {WIDTH{1'b1}};
    end else begin
      unit_disable <= ~en;
    end
  end
endmodule

// file: core/scg_sleep_gate_top.sv
// Sleep-mode clock gating register block with APB slave and interrupt
//
// Contract
// - A set enable bit keeps the unit clocked during sleep.
// - A clear enable bit stops the unit's clock and holds it disabled.
// - A bus access to a unit whose clock is gated off returns a bus fault.
// - Reset clears the whole register and every enable to zero.
// - Run, sleep and deep-sleep each have their own gating register.
// - Sleep registers apply only while auto clock gating is set.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "scg_params.svh"
module scg_sleep_gate_top #(
  parameter int UNITS = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operating state from the power controller
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  // Peripheral bus accesses, one bit per unit
  input wire logic [UNITS-1:0] unit_access,
  output logic unit_fault,
  // Peripheral clocks and disables
  output logic [UNITS-1:0] unit_clock,
  output logic [UNITS-1:0] unit_disable,
  // Interrupt
  output logic irq
);
  scg_gate_if gif ();

  logic [31:0] run_gate_q;
  logic [31:0] run_gate_d;
  logic [31:0] sleep_gate_q;
  logic [31:0] sleep_gate_d;
  logic [31:0] deep_gate_q;
  logic [31:0] deep_gate_d;
  logic [31:0] run_cfg_q;
  logic [31:0] run_cfg_d;
  logic [31:0] irq_stat_q;
  logic [31:0] irq_stat_d;
  logic [31:0] irq_mask_q;
  logic [31:0] irq_mask_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  scg_pkg::scg_mode_t mode_q;
  scg_pkg::scg_mode_t mode_d;

  // Keep only implemented bits; the rest read as zero
  function automatic logic [31:0] keep(input logic [31:0] v,
                                       input logic [31:0] m);
    keep = v & m;
  endfunction

  // Address decode
  wire hit_cfg = (paddr == `SCG_OFS_RUN_CFG);
  wire hit_run = (paddr == `SCG_OFS_RUN_GATE);
  wire hit_sleep = (paddr == `SCG_OFS_SLEEP_GATE);
  wire hit_deep = (paddr == `SCG_OFS_DEEP_GATE);
  wire hit_stat = (paddr == `SCG_OFS_IRQ_STAT);
  wire hit_mask = (paddr == `SCG_OFS_IRQ_MASK);
  wire hit_gsta = (paddr == `SCG_OFS_GATE_STAT);
  wire hit_any = hit_cfg | hit_run | hit_sleep | hit_deep |
                 hit_stat | hit_mask | hit_gsta;

  // Bus phases; the slave never inserts wait states
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_ok = access_ph & pwrite & hit_any;

  // Handshake: zero wait, error on an unmapped address
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata = prdata_q;

  // Read mux, sampled in the setup cycle
  wire [31:0] rd_mux =
    hit_cfg ? run_cfg_q :
    hit_run ? run_gate_q :
    hit_sleep ? sleep_gate_q :
    hit_deep ? deep_gate_q :
    hit_stat ? irq_stat_q :
    hit_mask ? irq_mask_q :
    hit_gsta ? gif.eff_en : 32'h0000_0000;
  assign prdata_d = setup_ph & ~pwrite ? rd_mux : prdata_q;

  // Register writes, implemented bits only
  assign run_gate_d = wr_ok & hit_run ?
    keep(pwdata, `SCG_GATE_MASK) : run_gate_q;
  assign sleep_gate_d = wr_ok & hit_sleep ?
    keep(pwdata, `SCG_GATE_MASK) : sleep_gate_q;
  assign deep_gate_d = wr_ok & hit_deep ?
    keep(pwdata, `SCG_GATE_MASK) : deep_gate_q;
  assign run_cfg_d = wr_ok & hit_cfg ?
    keep(pwdata, `SCG_CFG_MASK) : run_cfg_q;
  assign irq_mask_d = wr_ok & hit_mask ?
    keep(pwdata, `SCG_IRQ_MASK_BITS) : irq_mask_q;

  // Operating state; deep sleep outranks sleep
  assign mode_d = deep_sleep_req ? scg_pkg::SCG_DEEP :
                  sleep_req ? scg_pkg::SCG_SLEEP : scg_pkg::SCG_RUN;

  // Register file feeds the selector
  assign gif.run_en = run_gate_q;
  assign gif.sleep_en = sleep_gate_q;
  assign gif.deep_en = deep_gate_q;
  assign gif.auto_clock_gating = run_cfg_q[`SCG_ACG_BIT];
  assign gif.mode = mode_q;

  scg_mode_sel scg_mode_sel_i (
    .gif (gif.sel)
  );

  // Access to a gated unit faults instead of completing
  wire [UNITS-1:0] eff_en = gif.eff_en[UNITS-1:0];
  assign unit_fault = |(unit_access & ~eff_en);

  // Events
  wire ev_fault = unit_fault;
  wire ev_sleep = (mode_q == scg_pkg::SCG_RUN) &&
                  (mode_d != scg_pkg::SCG_RUN);
  wire ev_wake = (mode_q != scg_pkg::SCG_RUN) &&
                 (mode_d == scg_pkg::SCG_RUN);
  wire [31:0] ev_vec = {29'h0, ev_wake, ev_sleep, ev_fault};

  // Sticky status, write one to clear; a new event beats the clear
  wire [31:0] clr_vec = wr_ok & hit_stat ? pwdata : 32'h0000_0000;
  assign irq_stat_d = keep((irq_stat_q & ~clr_vec) | ev_vec,
                           `SCG_IRQ_MASK_BITS);

  // Level interrupt while an unmasked status bit is set
  assign irq = |(irq_stat_q & irq_mask_q);

  // Control registers, all cleared by reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      run_gate_q <= `SCG_GATE_RESET;
      sleep_gate_q <= `SCG_GATE_RESET;
      deep_gate_q <= `SCG_GATE_RESET;
      run_cfg_q <= `SCG_CFG_RESET;
    end else begin
      run_gate_q <= run_gate_d;
      sleep_gate_q <= sleep_gate_d;
      deep_gate_q <= deep_gate_d;
      run_cfg_q <= run_cfg_d;
    end
  end

  // Interrupt and bus state
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_stat_q <= `SCG_IRQ_RESET;
      irq_mask_q <= `SCG_IRQ_RESET;
      prdata_q <= 32'h0000_0000;
      mode_q <= scg_pkg::SCG_RUN;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      mode_q <= mode_d;
    end
  end

  // Clock gates follow the selected enables
  scg_unit_gate #(
    .WIDTH (UNITS)
  ) scg_unit_gate_i (
    .clock (clock),
    .resetn (resetn),
    .en (eff_en),
    .unit_clock (unit_clock),
    .unit_disable (unit_disable)
  );
endmodule

// file: dv/scg_sleep_gate_properties.sv
// Port checker for the sleep clock gate block
`timescale 1ns/10ps
`include "scg_params.svh"
module scg_sleep_gate_properties #(
  parameter int UNITS = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Units and interrupt
  input wire logic [UNITS-1:0] unit_access,
  input wire logic unit_fault,
  input wire logic [UNITS-1:0] unit_clock,
  input wire logic [UNITS-1:0] unit_disable,
  input wire logic irq
);
  localparam logic [UNITS-1:0] GM = UNITS'(`SCG_GATE_MASK);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Access phase decode
  wire acc = psel && penable;
  a_reset_clear: assert property ($rose(resetn) |->
    &unit_disable && prdata == 32'h0 && !irq) else $error("reset state");
  a_fault_gated: assert property (1 |=>
    $past(unit_fault) == |($past(unit_access) & unit_disable))
    else $error("fault differs from gating");
  a_no_access: assert property (unit_access == '0 |-> !unit_fault)
    else $error("fault without access");
  a_res_disabled: assert property (&(unit_disable | GM))
    else $error("reserved unit enabled");
  // Sampled on the falling edge, where a gated clock is high if it passes
  a_res_noclk: assert property (@(negedge clock)
    (unit_clock & ~GM) == '0)
    else $error("reserved unit clocked");
  a_bad_addr: assert property (acc && paddr == 12'h3fc |-> pslverr)
    else $error("no error on unmapped");
  a_good_addr: assert property (acc && paddr == 12'h114 |-> !pslverr)
    else $error("error on gate register");
  a_read_mask: assert property (acc && !pwrite && paddr == 12'h114 |->
    (prdata & ~32'(GM)) == 32'h0) else $error("reserved bits read");
endmodule
bind scg_sleep_gate_top scg_sleep_gate_properties #(.UNITS(UNITS))
  scg_sleep_gate_properties_i (.clock, .resetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .unit_access, .unit_fault,
  .unit_clock, .unit_disable, .irq);

// file: dv/scg_unit_model.sv
// Unit side model: counts pulses on a real and a reserved unit clock
`timescale 1ns/10ps
module scg_unit_model (
  // Gated unit clocks
  input wire logic [31:0] unit_clock,
  // Pulse counts
  output int pulses_on,
  output int pulses_off
);
  // A unit only advances on its own gated clock
  initial pulses_on = 0;
  initial pulses_off = 0;
  always @(posedge unit_clock[0]) pulses_on <= pulses_on + 1;
  always @(posedge unit_clock[3]) pulses_off <= pulses_off + 1;
endmodule

// file: dv/scg_sleep_gate_top_tb.sv
// Self-checking bench for the sleep clock gate block
`timescale 1ns/10ps
`include "scg_params.svh"
module scg_sleep_gate_top_tb;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic sleep_req = 0, deep_sleep_req = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, unit_access = 32'h0, rd;
  logic [31:0] prdata, unit_clock, unit_disable;
  logic pready, pslverr, unit_fault, irq, err;
  int fail_count = 0, n_checks = 0, cycles = 0, p0, p3;
  int pulses_on, pulses_off;
  scg_sleep_gate_top scg_sleep_gate_top_i (.clock, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleep_req, .deep_sleep_req, .unit_access, .unit_fault, .unit_clock,
    .unit_disable, .irq);
  scg_unit_model scg_unit_model_i (.unit_clock, .pulses_on, .pulses_off);
  always #20 clock = ~clock;
  // Compare and count
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // One APB transfer; an idle cycle before it keeps drivers apart
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard; the run needs under a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1;
    apb(0, `SCG_OFS_SLEEP_GATE, 0);
    chk("reset read", 0, rd);
    chk("reset disable", '1, unit_disable);
    apb(1, `SCG_OFS_SLEEP_GATE, '1);
    apb(0, `SCG_OFS_SLEEP_GATE, 0);
    chk("layout", `SCG_GATE_MASK, rd);
    $display("register test done");
    sleep_req <= 1;
    repeat (4) @(posedge clock);
    chk("no auto gating", '1, unit_disable);
    apb(1, `SCG_OFS_RUN_CFG, 32'h0800_0000);
    p0 = pulses_on;
    p3 = pulses_off;
    repeat (4) @(posedge clock);
    chk("sleep enables", ~`SCG_GATE_MASK, unit_disable);
    chk("clock on", 1, 32'(pulses_on > p0));
    chk("clock off", 0, pulses_off - p3);
    $display("sleep test done");
    apb(1, `SCG_OFS_SLEEP_GATE, 32'h0700_0000);
    unit_access <= 32'h0000_0001;
    @(posedge clock);
    chk("fault", 1, unit_fault);
    p0 = pulses_on;
    unit_access <= 32'h0100_0000;
    @(posedge clock);
    chk("no fault", 0, unit_fault);
    chk("unit clock stopped", 0, pulses_on - p0);
    chk("irq masked", 0, irq);
    unit_access <= 0;
    apb(1, `SCG_OFS_IRQ_MASK, 1);
    @(posedge clock);
    chk("irq", 1, irq);
    apb(1, `SCG_OFS_IRQ_STAT, 1);
    @(posedge clock);
    chk("irq cleared", 0, irq);
    $display("fault test done");
    apb(1, `SCG_OFS_DEEP_GATE, 32'h10);
    deep_sleep_req <= 1;
    repeat (3) @(posedge clock);
    chk("deep", ~32'h10, unit_disable);
    deep_sleep_req <= 0;
    sleep_req <= 0;
    apb(1, `SCG_OFS_RUN_GATE, 32'h4);
    repeat (2) @(posedge clock);
    chk("run", ~32'h4, unit_disable);
    apb(0, 12'h3fc, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(0, `SCG_OFS_GATE_STAT, 0);
    chk("effective", 32'h4, rd);
    apb(0, `SCG_OFS_IRQ_STAT, 0);
    chk("irq status", 32'h6, rd);
    $display("mode test done");
    // Reset in mid-run must clear a written register again
    apb(1, `SCG_OFS_SLEEP_GATE, '1);
    resetn <= 0;
    repeat (2) @(posedge clock);
    resetn <= 1;
    apb(0, `SCG_OFS_SLEEP_GATE, 0);
    chk("rerun read", 0, rd);
    chk("rerun disable", '1, unit_disable);
    $display("reset test done");
    end_of_test();
  end
endmodule
